// [hdl/ccd_consts.svh]
// Purpose: Offsets, field positions and reset values of the channel clock divider.
// Assumes: Eight-bit registers reached through a plain strobe register port.
// Notes: Definitions only; included by bare name.
`ifndef CCD_CONSTS_SVH
`define CCD_CONSTS_SVH

`define CCD_ADDR_W 10
`define CCD_DATA_W 8
`define CCD_CNT_W 4

`define CCD_OFS_CH1_COUNTS 10'h193
`define CCD_OFS_CH1_DIVCTL 10'h194
`define CCD_OFS_CH1_CHNCTL 10'h195
`define CCD_OFS_CH2_COUNTS 10'h196
`define CCD_OFS_CH2_DIVCTL 10'h197

`define CCD_RST_CH1_COUNTS 8'h33
`define CCD_RST_CH2_COUNTS 8'h11
`define CCD_RST_DIVCTL 8'h00
`define CCD_RST_CHNCTL 8'h00

`define CCD_F_LOW_HI 7
`define CCD_F_LOW_LO 4
`define CCD_F_HIGH_HI 3
`define CCD_F_HIGH_LO 0
`define CCD_B_BYPASS 7
`define CCD_B_IGN_SYNC 6
`define CCD_B_FORCE 5
`define CCD_B_START 4
`define CCD_F_PHASE_HI 3
`define CCD_F_PHASE_LO 0
`define CCD_B_PWRDN 2
`define CCD_B_DIRECT 1
`define CCD_B_DCC_DIS 0

`endif

// [hdl/ccd_pkg.sv]
// Purpose: Types shared by the channel clock divider modules.
// Assumes: Nothing beyond SystemVerilog.
// Notes: Constants live in ccd_consts.svh.
package ccd_pkg;
    // Gray codes along off, hold, delay, run.
    typedef enum logic [1:0] {
        CCD_ST_OFF = 2'b00,
        CCD_ST_HOLD = 2'b01,
        CCD_ST_DELAY = 2'b11,
        CCD_ST_RUN = 2'b10
    } ccd_state_t;
endpackage

// [hdl/ccd_divider.sv]
// Purpose: One programmable divider with separate low and high phase lengths.
// Assumes: The divider input clock is i_clk_sys; sync arrives already synchronised.
// Notes: Count changes take effect at the next phase reload.
`timescale 1ns/100ps
module ccd_divider import ccd_pkg::*; #(
    parameter int CNT_W = 4,
    parameter logic [CNT_W-1:0] RST_LOW = '0
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [CNT_W-1:0] i_low_cnt,
    input wire logic [CNT_W-1:0] i_high_cnt,
    input wire logic i_bypass,
    input wire logic i_ignore_sync,
    input wire logic i_force_high,
    input wire logic i_start_high,
    input wire logic [CNT_W-1:0] i_phase,
    input wire logic i_sync_active,
    output logic o_div_out,
    output logic o_bypassed
);
    ccd_state_t state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic level_reg, level_next;

    // Refuse a counter width the logic cannot serve, at elaboration.
    if (CNT_W < 1) begin : g_bad_cnt_w
        $error("ccd_divider: CNT_W must be at least 1");
    end

    // Next state; the count register holds cycles remaining minus one.
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        level_next = level_reg;
        if (i_bypass) begin
            state_next = CCD_ST_OFF;
            level_next = 1'b0;
        end else if (i_ignore_sync && i_force_high) begin
            // Forcing only counts with sync ignored, so a sync cannot fight it.
            state_next = CCD_ST_HOLD;
            level_next = 1'b1;
        end else if (!i_ignore_sync && i_sync_active) begin
            state_next = CCD_ST_HOLD;
            level_next = 1'b0;
        end else begin
            unique case (state_reg)
                CCD_ST_OFF, CCD_ST_HOLD: begin
                    level_next = i_start_high;
                    if (i_phase != '0) begin
                        state_next = CCD_ST_DELAY;
                        cnt_next = i_phase - 1'b1;
                    end else begin
                        state_next = CCD_ST_RUN;
                        cnt_next = i_start_high ? i_high_cnt : i_low_cnt;
                    end
                end
                CCD_ST_DELAY: begin
                    if (cnt_reg == '0) begin
                        state_next = CCD_ST_RUN;
                        cnt_next = level_reg ? i_high_cnt : i_low_cnt;
                    end else begin
                        cnt_next = cnt_reg - 1'b1;
                    end
                end
                CCD_ST_RUN: begin
                    if (cnt_reg == '0) begin
                        level_next = !level_reg;
                        cnt_next = level_reg ? i_low_cnt : i_high_cnt;
                    end else begin
                        cnt_next = cnt_reg - 1'b1;
                    end
                end
            endcase
        end
    end

    // Out of reset the divider runs low first with the reset low count.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= CCD_ST_RUN;
            cnt_reg <= RST_LOW;
            level_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            level_reg <= level_next;
        end
    end

    assign o_div_out = level_reg;
    assign o_bypassed = (state_reg == CCD_ST_OFF);
endmodule

// [hdl/ccd_top.sv]
// Purpose: Two-channel output clock divider with its configuration registers.
// Assumes: i_clk_sys is the distribution input clock; i_sync_n is an asynchronous pin.
// Notes: Clock routing outputs are select flags for the output muxes outside.
`timescale 1ns/100ps
`include "ccd_consts.svh"

module ccd_top import ccd_pkg::*; #(
    parameter int ADDR_W = `CCD_ADDR_W,
    parameter int DATA_W = `CCD_DATA_W,
    parameter int CNT_W = `CCD_CNT_W
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [ADDR_W-1:0] i_reg_addr,
    input wire logic [DATA_W-1:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [DATA_W-1:0] o_reg_rdata,
    output logic o_reg_rvalid,
    input wire logic i_sync_n,
    input wire logic i_global_route_sel,
    output logic o_ch1_output_a,
    output logic o_ch1_output_b,
    output logic o_ch1_output_c,
    output logic o_ch1_route_clk,
    output logic o_ch1_powered_down,
    output logic o_ch1_duty_cycle_fix_en,
    output logic o_ch2_output_a,
    output logic o_ch2_output_b,
    output logic o_ch2_output_c,
    output logic o_ch2_route_clk
);
    localparam int NREG = 5;

    logic [DATA_W-1:0] regs_reg [NREG];
    logic [DATA_W-1:0] regs_next [NREG];
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;
    logic sync1_reg, sync2_reg, sync3_reg, sync_lvl_reg, sync_lvl_next;
    logic ch1_div, ch1_byp, ch2_div, ch2_byp;
    logic [2:0] ch1_out_reg, ch1_out_next, ch2_out_reg, ch2_out_next;
    logic ch1_route_reg, ch1_route_next, ch2_route_reg, ch2_route_next;
    logic ch1_pd_reg, ch1_pd_next, ch1_dcc_reg, ch1_dcc_next;
    logic ch1_direct;

    // The field layout is fixed, so other widths are refused at elaboration.
    if (ADDR_W < 9 || DATA_W != 8 || CNT_W != 4) begin : g_bad_widths
        $error("ccd_top: register layout needs ADDR_W>=9, DATA_W=8, CNT_W=4");
    end

    // Register offsets in table order; index i sits at reg_ofs(i).
    function automatic logic [ADDR_W-1:0] reg_ofs(input int idx);
        logic [ADDR_W-1:0] ofs;
        ofs = '0;
        case (idx)
            0: ofs = ADDR_W'(`CCD_OFS_CH1_COUNTS);
            1: ofs = ADDR_W'(`CCD_OFS_CH1_DIVCTL);
            2: ofs = ADDR_W'(`CCD_OFS_CH1_CHNCTL);
            3: ofs = ADDR_W'(`CCD_OFS_CH2_COUNTS);
            default: ofs = ADDR_W'(`CCD_OFS_CH2_DIVCTL);
        endcase
        return ofs;
    endfunction

    function automatic logic [DATA_W-1:0] reg_rst(input int idx);
        logic [DATA_W-1:0] v;
        v = '0;
        case (idx)
            0: v = DATA_W'(`CCD_RST_CH1_COUNTS);
            2: v = DATA_W'(`CCD_RST_CHNCTL);
            3: v = DATA_W'(`CCD_RST_CH2_COUNTS);
            default: v = DATA_W'(`CCD_RST_DIVCTL);
        endcase
        return v;
    endfunction

    // Writes store the whole byte; a read answers one cycle later, zero when unmapped.
    always_comb begin
        rdata_next = '0;
        rvalid_next = i_reg_rd;
        for (int i = 0; i < NREG; i++) begin
            regs_next[i] = regs_reg[i];
            if (i_reg_wr && i_reg_addr == reg_ofs(i)) begin
                regs_next[i] = i_reg_wdata;
            end
            if (i_reg_rd && i_reg_addr == reg_ofs(i)) begin
                rdata_next = regs_reg[i];
            end
        end
    end

    // Register file storage with per-register reset constants.
    generate
        for (genvar g = 0; g < NREG; g++) begin : g_regs
            always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    regs_reg[g] <= reg_rst(g);
                end else begin
                    regs_reg[g] <= regs_next[g];
                end
            end
        end
    endgenerate

    // Sync pin: a change counts once the second and third stages agree.
    always_comb begin
        sync_lvl_next = (sync2_reg == sync3_reg) ? !sync3_reg : sync_lvl_reg;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
            sync3_reg <= 1'b1;
            sync_lvl_reg <= 1'b0;
            rdata_reg <= '0;
            rvalid_reg <= 1'b0;
        end else begin
            sync1_reg <= i_sync_n;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            sync_lvl_reg <= sync_lvl_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // Channel one divider.
    ccd_divider #(
        .CNT_W(CNT_W),
        .RST_LOW(CNT_W'(`CCD_RST_CH1_COUNTS >> `CCD_F_LOW_LO))
    ) u_div1 (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_low_cnt(regs_reg[0][`CCD_F_LOW_HI:`CCD_F_LOW_LO]),
        .i_high_cnt(regs_reg[0][`CCD_F_HIGH_HI:`CCD_F_HIGH_LO]),
        .i_bypass(regs_reg[1][`CCD_B_BYPASS]),
        .i_ignore_sync(regs_reg[1][`CCD_B_IGN_SYNC]),
        .i_force_high(regs_reg[1][`CCD_B_FORCE]),
        .i_start_high(regs_reg[1][`CCD_B_START]),
        .i_phase(regs_reg[1][`CCD_F_PHASE_HI:`CCD_F_PHASE_LO]),
        .i_sync_active(sync_lvl_reg),
        .o_div_out(ch1_div),
        .o_bypassed(ch1_byp)
    );

    // Channel two divider, same layout at its own registers.
    ccd_divider #(
        .CNT_W(CNT_W),
        .RST_LOW(CNT_W'(`CCD_RST_CH2_COUNTS >> `CCD_F_LOW_LO))
    ) u_div2 (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_low_cnt(regs_reg[3][`CCD_F_LOW_HI:`CCD_F_LOW_LO]),
        .i_high_cnt(regs_reg[3][`CCD_F_HIGH_HI:`CCD_F_HIGH_LO]),
        .i_bypass(regs_reg[4][`CCD_B_BYPASS]),
        .i_ignore_sync(regs_reg[4][`CCD_B_IGN_SYNC]),
        .i_force_high(regs_reg[4][`CCD_B_FORCE]),
        .i_start_high(regs_reg[4][`CCD_B_START]),
        .i_phase(regs_reg[4][`CCD_F_PHASE_HI:`CCD_F_PHASE_LO]),
        .i_sync_active(sync_lvl_reg),
        .o_div_out(ch2_div),
        .o_bypassed(ch2_byp)
    );

    // The global routing bit wins over direct, so direct then has no effect.
    assign ch1_direct = regs_reg[2][`CCD_B_DIRECT] && !i_global_route_sel;

    // Output stage; power-down parks channel one's pins low and drops its clock routing.
    always_comb begin
        ch1_pd_next = regs_reg[2][`CCD_B_PWRDN];
        ch1_dcc_next = !regs_reg[2][`CCD_B_DCC_DIS];
        if (ch1_pd_next) begin
            ch1_out_next = 3'h0;
            ch1_route_next = 1'b0;
        end else begin
            ch1_out_next = {3{ch1_div && !ch1_direct}};
            ch1_route_next = ch1_direct || ch1_byp;
        end
        ch2_out_next = {3{ch2_div}};
        ch2_route_next = ch2_byp;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ch1_out_reg <= 3'h0;
            ch2_out_reg <= 3'h0;
            ch1_route_reg <= 1'b0;
            ch2_route_reg <= 1'b0;
            ch1_pd_reg <= 1'b0;
            ch1_dcc_reg <= 1'b1;
        end else begin
            ch1_out_reg <= ch1_out_next;
            ch2_out_reg <= ch2_out_next;
            ch1_route_reg <= ch1_route_next;
            ch2_route_reg <= ch2_route_next;
            ch1_pd_reg <= ch1_pd_next;
            ch1_dcc_reg <= ch1_dcc_next;
        end
    end

    assign o_reg_rdata = rdata_reg;
    assign o_reg_rvalid = rvalid_reg;
    assign o_ch1_output_a = ch1_out_reg[0];
    assign o_ch1_output_b = ch1_out_reg[1];
    assign o_ch1_output_c = ch1_out_reg[2];
    assign o_ch1_route_clk = ch1_route_reg;
    assign o_ch1_powered_down = ch1_pd_reg;
    assign o_ch1_duty_cycle_fix_en = ch1_dcc_reg;
    assign o_ch2_output_a = ch2_out_reg[0];
    assign o_ch2_output_b = ch2_out_reg[1];
    assign o_ch2_output_c = ch2_out_reg[2];
    assign o_ch2_route_clk = ch2_route_reg;
endmodule

// [verif/ccd_top_checker.sv]
// Purpose: Port-level checks for the channel clock divider.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes: Bound to every ccd_top instance at the foot of this file.
`timescale 1ns/100ps
module ccd_top_checker #(
    parameter int ADDR_W = 10,
    parameter int DATA_W = 8
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [ADDR_W-1:0] i_reg_addr,
    input wire logic [DATA_W-1:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [DATA_W-1:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    input wire logic o_ch1_output_a,
    input wire logic o_ch1_output_b,
    input wire logic o_ch1_output_c,
    input wire logic o_ch1_route_clk,
    input wire logic o_ch1_powered_down,
    input wire logic o_ch1_duty_cycle_fix_en,
    input wire logic o_ch2_output_a,
    input wire logic o_ch2_route_clk
);
    // Every check runs on the one clock and is silenced in reset.
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    // Write decodes; flag pins lag the register by one flop, divider pins by two, hence the delays.
    logic w194;
    logic w195;
    logic w197;
    assign w194 = i_reg_wr && (i_reg_addr == 10'h194);
    assign w195 = i_reg_wr && (i_reg_addr == 10'h195);
    assign w197 = i_reg_wr && (i_reg_addr == 10'h197);
    AST_RD_ANSWER: assert property (i_reg_rd |=> o_reg_rvalid)
        else $error("read got no answer");
    AST_RD_IDLE: assert property (!i_reg_rd |=> !o_reg_rvalid && o_reg_rdata == 8'h00)
        else $error("read answer without a read");
    AST_GROUP: assert property (o_ch1_output_a == o_ch1_output_b && o_ch1_output_b == o_ch1_output_c)
        else $error("channel one pins differ");
    AST_PD_PARK: assert property (o_ch1_powered_down && $past(o_ch1_powered_down) |-> !o_ch1_output_a && !o_ch1_route_clk)
        else $error("powered-down channel still active");
    AST_PD_WRITE: assert property (w195 |-> ##3 o_ch1_powered_down == $past(i_reg_wdata[2], 3))
        else $error("power-down flag wrong");
    AST_DCC: assert property (w195 |-> ##3 o_ch1_duty_cycle_fix_en == !$past(i_reg_wdata[0], 3))
        else $error("correction enable wrong");
    AST_CH2_HIGH: assert property ($rose(o_ch2_output_a) |-> ##2 !o_ch2_output_a)
        else $error("channel two high too long");
    AST_FORCE: assert property (w194 && i_reg_wdata[7:5] == 3'b011 && !o_ch1_powered_down |-> ##4 o_ch1_output_a [*4])
        else $error("forced high level missing");
    AST_BYP2: assert property (w197 && i_reg_wdata[7] |-> ##4 o_ch2_route_clk && !o_ch2_output_a)
        else $error("bypass not applied");
    // Main scenarios are seen at least once.
    COV_BYPASS: cover property ($rose(o_ch2_route_clk));
    COV_READ: cover property (o_reg_rvalid);
    COV_PD: cover property ($fell(o_ch1_powered_down));
endmodule

bind ccd_top ccd_top_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) ccd_top_checker_i (
    .i_clk_sys, .i_rst_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
    .o_reg_rdata, .o_reg_rvalid, .o_ch1_output_a, .o_ch1_output_b, .o_ch1_output_c,
    .o_ch1_route_clk, .o_ch1_powered_down, .o_ch1_duty_cycle_fix_en,
    .o_ch2_output_a, .o_ch2_route_clk
);

// [verif/ccd_top_tb_top.sv]
// Purpose: Self-checking bench for the two-channel clock divider.
// Assumes: Strobes are one-cycle pulses driven at the falling edge.
// Notes: Phase lengths are counted at falling edges, where pins are settled.
`timescale 1ns/100ps
module ccd_top_tb_top;
    logic i_clk_sys = 1'b0;
    logic i_rst_n = 1'b0;
    logic [9:0] i_reg_addr = 10'h000;
    logic [7:0] i_reg_wdata = 8'h00;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic i_sync_n = 1'b1;
    logic i_global_route_sel = 1'b0;
    logic [7:0] o_reg_rdata;
    logic o_reg_rvalid, o_ch1_output_a, o_ch1_output_b, o_ch1_output_c, o_ch1_route_clk;
    logic o_ch1_powered_down, o_ch1_duty_cycle_fix_en, o_ch2_output_a, o_ch2_output_b;
    logic o_ch2_output_c, o_ch2_route_clk;
    int n_errors = 0;
    int cmp_count = 0;
    int lo, hi;

    ccd_top ccd_top_i (
        .i_clk_sys, .i_rst_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
        .o_reg_rdata, .o_reg_rvalid, .i_sync_n, .i_global_route_sel,
        .o_ch1_output_a, .o_ch1_output_b, .o_ch1_output_c, .o_ch1_route_clk,
        .o_ch1_powered_down, .o_ch1_duty_cycle_fix_en, .o_ch2_output_a,
        .o_ch2_output_b, .o_ch2_output_c, .o_ch2_route_clk
    );

    // A 5 ns period gives the 200 MHz divider input clock.
    initial begin
        forever #2.5 i_clk_sys = ~i_clk_sys;
    end

    // Verdict and comparison helpers.
    task automatic tally_and_finish();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask
    // Register port cycles; a read answers one edge after it is taken.
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(negedge i_clk_sys);
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_wr = 1'b1;
        @(negedge i_clk_sys);
        i_reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        @(negedge i_clk_sys);
        i_reg_addr = a;
        i_reg_rd = 1'b1;
        @(negedge i_clk_sys);
        chk(8'(o_reg_rvalid), 8'h01);
        chk(o_reg_rdata, e);
        i_reg_rd = 1'b0;
    endtask
    // Pin level tracking; every wait is bounded so a stuck pin ends the run.
    function automatic logic lvl(input bit ch);
        return ch ? o_ch2_output_a : o_ch1_output_a;
    endfunction
    task automatic run_len(input bit ch, input logic v, output int n);
        n = 0;
        while (lvl(ch) === v) begin
            n++;
            if (n > 200) begin
                n_errors++;
                $display("MISMATCH at %0t: output level stuck", $time);
                tally_and_finish();
            end
            @(negedge i_clk_sys);
        end
    endtask
    task automatic meas(input bit ch, output int l, output int h);
        int t;
        run_len(ch, 1'b1, t);
        run_len(ch, 1'b0, t);
        run_len(ch, 1'b1, h);
        run_len(ch, 1'b0, l);
    endtask

    task automatic t_reset();
        rd(10'h193, 8'h33);
        rd(10'h194, 8'h00);
        rd(10'h195, 8'h00);
        rd(10'h196, 8'h11);
        rd(10'h197, 8'h00);
        rd(10'h198, 8'h00);
        chk(8'(o_ch1_duty_cycle_fix_en), 8'h01);
        meas(1'b0, lo, hi);
        chk(8'(lo), 8'h04);
        chk(8'(hi), 8'h04);
        meas(1'b1, lo, hi);
        chk(8'(lo), 8'h02);
        chk(8'(hi), 8'h02);
        // A high phase has just begun, so the other two pins run 1, 1, 0, 0.
        for (int i = 0; i < 4; i++) begin
            chk({6'h00, o_ch2_output_b, o_ch2_output_c}, (i < 2) ? 8'h03 : 8'h00);
            cyc(1);
        end
    endtask
    task automatic t_counts();
        wr(10'h193, 8'h52);
        rd(10'h193, 8'h52);
        meas(1'b0, lo, hi);
        meas(1'b0, lo, hi);
        chk(8'(lo), 8'h06);
        chk(8'(hi), 8'h03);
        wr(10'h193, 8'h00);
        meas(1'b0, lo, hi);
        meas(1'b0, lo, hi);
        chk(8'(lo + hi), 8'h02);
    endtask
    // Bypass is set just after a falling edge so no high phase is cut short.
    task automatic t_bypass();
        run_len(1'b1, 1'b0, lo);
        run_len(1'b1, 1'b1, lo);
        wr(10'h197, 8'h80);
        cyc(3);
        chk(8'(o_ch2_route_clk), 8'h01);
        chk(8'(o_ch2_output_a), 8'h00);
        wr(10'h197, 8'h00);
        meas(1'b1, lo, hi);
        chk(8'(lo + hi), 8'h04);
    endtask
    task automatic t_force();
        wr(10'h194, 8'h20);
        meas(1'b0, lo, hi);
        chk(8'(lo + hi), 8'h02);
        wr(10'h194, 8'h60);
        cyc(4);
        for (int i = 0; i < 6; i++) begin
            chk(8'(o_ch1_output_a), 8'h01);
            cyc(1);
        end
        wr(10'h194, 8'h00);
    endtask
    // Restart after sync: start high, phase 3, high count 0 gives 4 cycles high.
    task automatic t_sync();
        i_sync_n = 1'b0;
        cyc(8);
        for (int i = 0; i < 6; i++) begin
            chk(8'(o_ch1_output_a), 8'h00);
            cyc(1);
        end
        wr(10'h194, 8'h40);
        meas(1'b0, lo, hi);
        chk(8'(lo + hi), 8'h02);
        wr(10'h194, 8'h13);
        cyc(6);
        chk(8'(o_ch1_output_a), 8'h00);
        i_sync_n = 1'b1;
        run_len(1'b0, 1'b0, lo);
        run_len(1'b0, 1'b1, hi);
        chk(8'(hi), 8'h04);
        wr(10'h194, 8'h00);
    endtask
    task automatic t_chan();
        wr(10'h195, 8'h04);
        cyc(3);
        chk(8'(o_ch1_powered_down), 8'h01);
        chk(8'(o_ch1_output_a | o_ch1_route_clk), 8'h00);
        wr(10'h195, 8'h02);
        cyc(3);
        chk(8'(o_ch1_route_clk), 8'h01);
        i_global_route_sel = 1'b1;
        cyc(3);
        chk(8'(o_ch1_route_clk), 8'h00);
        wr(10'h195, 8'h01);
        cyc(3);
        chk(8'(o_ch1_duty_cycle_fix_en), 8'h00);
        rd(10'h195, 8'h01);
        i_global_route_sel = 1'b0;
    endtask

    // Reset for four cycles, then the scenarios in turn.
    initial begin
        cyc(4);
        i_rst_n = 1'b1;
        t_reset();
        t_counts();
        t_bypass();
        t_force();
        t_sync();
        t_chan();
        tally_and_finish();
    end
endmodule
